//--- bench/rcs_reset_src.sv
// Reset source and address-19 strap line model.
// Assumes one output-clock period is two clk cycles.
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_src (
  input wire logic clk,
  input wire logic strap_oe,
  input wire logic strap_out,
  output logic reset_in_n,
  output logic strap_in
);
  logic strap_low = 1'b0;
  assign strap_in = strap_oe ? strap_out : !strap_low;
  initial reset_in_n = 1'b1;
  task automatic pulse(input int periods, input int extra, input logic strap);
    @(posedge clk);
    #1 reset_in_n = 1'b0;
    strap_low = strap;
    repeat (2 * periods + extra) @(posedge clk);
    #1 reset_in_n = 1'b1;
    @(posedge clk);
    #1 strap_low = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- bench/rcs_top_tb_top.sv
// Random-load bench for the reset-release block.
// Assumes the reset source model drives the reset and strap pins.
`timescale 1ns/1ps
`default_nettype none
module rcs_top_tb_top
  import rcs_pkg::*;
;
  logic clk = 0, reset_n = 0, bca = 0, lk = 0, a19 = 0;
  logic [2:0] ua = 0, uo, pu;
  logic rin_n, sin, co, be_o, fs_o, ab_o, lo, ao, wp, em_o, ts;
  rcs_pin_ctl_t oe;
  logic ec, st, prev, be, fs, ab, em, nc, rel, pl, pa;
  logic [2:0] cnt;
  logic [15:0] x = 16'h88B0;
  int failures = 0, samples_checked = 0;
  always #20 clk = !clk;
  rcs_reset_src src (.clk(clk), .strap_oe(oe.addr19), .strap_out(ao),
    .reset_in_n(rin_n), .strap_in(sin));
  rcs_top dut (.clk(clk), .reset_n(reset_n), .reset_in_n(rin_n), .bus_cycle_active(bca),
    .core_lock(lk), .core_upper_addr(ua), .core_addr19(a19), .addr19_test_strap_in(sin),
    .clk_out(co), .bus_enable(be_o), .bus_first_start(fs_o), .bus_abort(ab_o),
    .lock_out(lo), .upper_address_lines_out(uo), .addr19_test_strap_out(ao),
    .pin_oe(oe), .weak_pullup_en(wp), .emulation_mode(em_o), .reset_too_short(ts));
  function automatic logic [15:0] xs(input logic [15:0] v);
    v ^= v << 7;
    v ^= v >> 9;
    v ^= v << 8;
    return v;
  endfunction
  task automatic chk1(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk5(input string n, input logic [4:0] e, input logic [4:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reference of clock phase and bus gating
  assign rel = rin_n && !prev;
  assign nc = ((rel && ec) || st) ? 1'b0 : !ec;
  always @(posedge clk) begin
    if (!reset_n) begin
      {ec, st, prev, be, fs, ab, em, cnt} <= '0;
      // Pin outputs rest high in reset
      {pl, pu, pa} <= 5'h1F;
    end else begin
      ec <= nc;
      st <= rel && ec;
      prev <= rin_n;
      ab <= !rin_n && bca;
      fs <= rin_n && cnt == 3'h7 && !be;
      be <= rin_n && (be || cnt == 3'h7);
      {pl, pu, pa} <= {lk, ua, a19};
      if (rel) em <= !sin;
      if (!rin_n) cnt <= 3'h0;
      else if (nc && !ec && cnt != 3'h7) cnt <= cnt + 3'h1;
    end
  end
  always @(posedge clk) begin
    #1;
    x = xs(x);
    {bca, lk, a19, ua} = x[5:0];
  end
  always @(negedge clk) begin
    if (reset_n) begin
      chk1("clk_out", ec, co);
      chk1("bus_enable", be, be_o);
      chk1("bus_first_start", fs, fs_o);
      chk1("bus_abort", ab, ab_o);
      chk5("pin_oe", {5{be}}, oe);
      chk1("weak_pullup_en", !be, wp);
      chk5("pins", {pl, pu, pa}, {lo, uo, ao});
      chk1("emulation_mode", em, em_o);
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (24) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      src.pulse(i == 0 ? 2 : 4 + x[1:0], x[2], x[3]);
      repeat (26) @(posedge clk);
      chk1("reset_too_short", i == 0, ts);
      $display("test %0d done", i);
    end
    print_verdict;
  end
  initial begin
    #50000;
    failures++;
    print_verdict;
  end
endmodule
`default_nettype wire

//--- src/rcs_period_counter.sv
// Saturating counter of output-clock periods with a compare target.
// Assumes tick is a one-cycle pulse per output-clock period.
`timescale 1ns/1ps
`default_nettype none
module rcs_period_counter
  import rcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clr,
  input wire logic tick,
  input wire logic [2:0] target,
  output logic [2:0] count,
  output logic reached
);
  logic [2:0] next_count;
  wire at_target = (count >= target);

  assign next_count = clr ? CNT_ZERO : ((tick && !at_target) ? count + 3'h1 : count);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= CNT_ZERO;
      reached <= 1'b0;
    end else begin
      count <= next_count;
      reached <= (next_count >= target);
    end
  end
endmodule
`default_nettype wire

//--- src/rcs_pkg.sv
// Constants and types shared by the reset-release and clock-output logic.
// Assumes one clock (the input clock) and a synchronous active-low reset.
package rcs_pkg;
  // Input clock rate in MHz
  localparam int CLKIN_MHZ = 25;
  // Low stretch of the output clock after a release seen while it is high
  localparam logic [1:0] STRETCH_CLKIN = 2'h2;
  // Output-clock periods from release to the first bus cycle
  localparam logic [2:0] WAIT_PERIODS = 3'h7;
  // Least low time of the reset input, in output-clock periods
  localparam logic [2:0] MIN_LOW_PERIODS = 3'h4;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [1:0] STRETCH_ZERO = 2'h0;

  typedef enum logic [1:0] {
    RCS_ST_RESET = 2'b00,
    RCS_ST_WAIT = 2'b01,
    RCS_ST_RUN = 2'b10
  } rcs_state_t;

  // Output enables of the bus pins that turn to inputs during reset
  typedef struct packed {
    logic lock;
    logic addr19;
    logic [2:0] upper;
  } rcs_pin_ctl_t;

  localparam rcs_pin_ctl_t PIN_CTL_OFF = '{lock: 1'b0, addr19: 1'b0, upper: 3'h0};
endpackage

//--- src/rcs_top.sv
// Reset release, output clock divider and bus start gating.
// Assumes the reset input pin and bus inputs are synchronous to clk.
// What this block does
// - Realign the output clock phase on the rising edge of the reset input.
// - Release while output clock high: force it low for two input clocks.
// - Release while output clock low: output clock waveform left unchanged.
// - Wait seven output-clock periods after release before the first bus cycle.
// - Reset asserted mid-operation aborts any bus cycle on the next clk edge.
// - During reset lock and upper address pins become inputs with pull-ups.
// - Only the address-19 strap may be pulled low; it selects emulation mode.
`timescale 1ns/1ps
`default_nettype none
module rcs_top
  import rcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reset_in_n,
  input wire logic bus_cycle_active,
  input wire logic core_lock,
  input wire logic [2:0] core_upper_addr,
  input wire logic core_addr19,
  input wire logic addr19_test_strap_in,
  output logic clk_out,
  output logic bus_enable,
  output logic bus_first_start,
  output logic bus_abort,
  output logic lock_out,
  output logic [2:0] upper_address_lines_out,
  output logic addr19_test_strap_out,
  output rcs_pin_ctl_t pin_oe,
  output logic weak_pullup_en,
  output logic emulation_mode,
  output logic reset_too_short
);
  rcs_state_t state;
  rcs_state_t next_state;
  logic reset_in_prev;
  logic [1:0] stretch;
  logic [1:0] next_stretch;
  logic next_clk_out;
  logic [2:0] wait_count;
  logic wait_done;
  logic low_ok;

  // Rising edge of the reset input
  wire release_edge = reset_in_n && !reset_in_prev;
  wire in_reset = !reset_in_n;
  wire clk_out_rise = next_clk_out && !clk_out;

  assign next_stretch = (release_edge && clk_out) ? STRETCH_CLKIN - 2'h1 :
                        (stretch != STRETCH_ZERO) ? stretch - 2'h1 : STRETCH_ZERO;
  assign next_clk_out = (release_edge && clk_out) ? 1'b0 :
                        (stretch != STRETCH_ZERO) ? 1'b0 : !clk_out;

  always_comb begin
    case (state)
      RCS_ST_RESET: next_state = RCS_ST_WAIT;
      RCS_ST_WAIT: next_state = wait_done ? RCS_ST_RUN : RCS_ST_WAIT;
      RCS_ST_RUN: next_state = RCS_ST_RUN;
      default: next_state = RCS_ST_RESET;
    endcase
    if (in_reset) begin
      next_state = RCS_ST_RESET;
    end
  end

  wire next_run = (next_state == RCS_ST_RUN);

  rcs_pin_ctl_t next_pin_oe;
  assign next_pin_oe = next_run ? rcs_pin_ctl_t'{lock: 1'b1, addr19: 1'b1, upper: 3'h7} :
                       PIN_CTL_OFF;

  rcs_period_counter u_wait (
    .clk(clk),
    .reset_n(reset_n),
    .clr(in_reset),
    .tick(clk_out_rise),
    .target(WAIT_PERIODS),
    .count(wait_count),
    .reached(wait_done)
  );

  rcs_period_counter u_low (
    .clk(clk),
    .reset_n(reset_n),
    .clr(reset_in_n),
    .tick(clk_out_rise),
    .target(MIN_LOW_PERIODS),
    .count(),
    .reached(low_ok)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= RCS_ST_RESET;
      reset_in_prev <= 1'b0;
      stretch <= STRETCH_ZERO;
      clk_out <= 1'b0;
    end else begin
      state <= next_state;
      reset_in_prev <= reset_in_n;
      stretch <= next_stretch;
      clk_out <= next_clk_out;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_enable <= 1'b0;
      bus_first_start <= 1'b0;
      bus_abort <= 1'b0;
    end else begin
      bus_enable <= next_run;
      bus_first_start <= next_run && (state == RCS_ST_WAIT);
      bus_abort <= in_reset && bus_cycle_active;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_oe <= PIN_CTL_OFF;
      weak_pullup_en <= 1'b1;
      lock_out <= 1'b1;
      upper_address_lines_out <= 3'h7;
      addr19_test_strap_out <= 1'b1;
    end else begin
      pin_oe <= next_pin_oe;
      weak_pullup_en <= !next_run;
      lock_out <= core_lock;
      upper_address_lines_out <= core_upper_addr;
      addr19_test_strap_out <= core_addr19;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      emulation_mode <= 1'b0;
      reset_too_short <= 1'b0;
    end else if (release_edge) begin
      emulation_mode <= !addr19_test_strap_in;
      reset_too_short <= !low_ok;
    end
  end

  property p_realign;
    @(posedge clk) disable iff (!reset_n)
    (release_edge && clk_out) |=> (stretch == 2'h1);
  endproperty
  a_realign: assert property (p_realign) else $error("no realign at release");

  property p_stretch;
    @(posedge clk) disable iff (!reset_n)
    (release_edge && clk_out) |=> !clk_out [*2] ##1 clk_out;
  endproperty
  a_stretch: assert property (p_stretch) else $error("bad low stretch");

  property p_no_stretch;
    @(posedge clk) disable iff (!reset_n)
    (release_edge && !clk_out) |=> clk_out ##1 !clk_out;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("low phase disturbed");

  property p_wait;
    @(posedge clk) disable iff (!reset_n)
    $rose(bus_enable) |-> (wait_count == 3'h7) && $past(reset_in_n);
  endproperty
  a_wait: assert property (p_wait) else $error("bus started early");

  property p_wait_window;
    @(posedge clk) disable iff (!reset_n)
    (release_edge && !clk_out) ##1 reset_in_n [*8] |-> !bus_enable;
  endproperty
  a_wait_window: assert property (p_wait_window) else $error("bus on before wait");

  property p_abort;
    @(posedge clk) disable iff (!reset_n)
    (in_reset && bus_cycle_active) |=> bus_abort && !bus_enable;
  endproperty
  a_abort: assert property (p_abort) else $error("cycle not aborted");

  property p_float;
    @(posedge clk) disable iff (!reset_n)
    in_reset |=> (pin_oe == PIN_CTL_OFF) && weak_pullup_en;
  endproperty
  a_float: assert property (p_float) else $error("pins driven in reset");

  property p_strap;
    @(posedge clk) disable iff (!reset_n)
    release_edge |=> (emulation_mode == !$past(addr19_test_strap_in));
  endproperty
  a_strap: assert property (p_strap) else $error("strap not caught");

  property p_divide;
    @(posedge clk) disable iff (!reset_n)
    (!release_edge && stretch == STRETCH_ZERO) |=> (clk_out != $past(clk_out));
  endproperty
  a_divide: assert property (p_divide) else $error("clock not divided");

  property p_first_start;
    @(posedge clk) disable iff (!reset_n)
    bus_first_start |-> bus_enable && !$past(bus_enable);
  endproperty
  a_first_start: assert property (p_first_start) else $error("first start misplaced");

  property p_reset_drop;
    @(posedge clk) disable iff (!reset_n)
    in_reset |=> !bus_enable && !bus_first_start;
  endproperty
  a_reset_drop: assert property (p_reset_drop) else $error("bus left on in reset");

  property p_strap_hold;
    @(posedge clk) disable iff (!reset_n)
    !release_edge |=> $stable(emulation_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed off release");
endmodule
`default_nettype wire
